// *** design/acc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_top
	import acc_pkg::*;
#(
	parameter int unsigned STAB_CYCLES = `ACC_STAB_CYCLES
)
(
	input  wire logic                   mclk_i,
	input  wire logic                   reset_n_i,
	input  wire logic [`ACC_ADDR_W-1:0] addr_i,
	input  wire logic [`ACC_DATA_W-1:0] wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic [`ACC_DATA_W-1:0]      rdata_o,
	input  wire logic                   halt_i,
	input  wire logic                   comparator_i,
	output logic                        irq_o,
	output logic                        converter_power_o,
	output logic                        sample_o,
	output logic [`ACC_CHAN_N-1:0]      analog_input_en_o,
	output logic [`ACC_DATA_W-1:0]      dac_code_o
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	acc_bus_t                  bus;
	acc_top_st_t               st_q;
	acc_top_st_t               st_d;
	logic                      running;
	logic                      wr_csr;
	logic                      rd_result;
	logic                      stab_load;
	logic                      stab_abort;
	logic                      stab_done;
	logic                      cmp_val;
	logic                      sar_start;
	logic                      sar_decide;
	logic [`ACC_BIT_IDX_W-1:0] sar_bit;
	logic [`ACC_DATA_W-1:0]    sar_code;
	logic [`ACC_DATA_W-1:0]    sar_next;
	logic [`ACC_CYC_W-1:0]     conv_ofs;
	logic                      conv_done;
	logic [`ACC_IRQ_W-1:0]     irq_evt;
	logic [`ACC_IRQ_W-1:0]     irq_clr;
	logic [`ACC_DATA_W-1:0]    csr_rd;
	logic                      all_hi_q;
	logic                      all_lo_q;

	assign bus       = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign running   = (st_q.phase == ACC_RUN);
	assign wr_csr    = bus.wr && (bus.addr == `ACC_OFS_CSR);
	assign rd_result = bus.rd && (bus.addr == `ACC_OFS_RESULT);

	// ------------------------------------------------------------------------
	// Conversion timing
	// ------------------------------------------------------------------------
	// The comparator is judged only once two synchroniser stages agree, so
	// each bit slot is sized to cover that latency plus one settling cycle.
	assign cmp_val    = (st_q.cmp_sync[1] == st_q.cmp_sync[2]) ? st_q.cmp_sync[1] : st_q.cmp;
	assign conv_ofs   = st_q.cyc - `ACC_CYC_W'(`ACC_SAMPLE_CYCLES);
	assign sar_start  = running && !wr_csr && !halt_i &&
		(st_q.cyc == `ACC_CYC_W'(`ACC_SAMPLE_CYCLES - 1));
	assign sar_decide = running && (st_q.cyc >= `ACC_CYC_W'(`ACC_SAMPLE_CYCLES)) &&
		((conv_ofs % `ACC_BIT_SLOT) == `ACC_BIT_SLOT - 1);
	assign sar_bit    = `ACC_BIT_IDX_W'(`ACC_DATA_W - 1 - int'(conv_ofs / `ACC_BIT_SLOT));
	// write or halt discards the result
	assign conv_done  = sar_decide && !wr_csr && !halt_i &&
		(st_q.cyc == `ACC_CYC_W'(`ACC_CONV_CYCLES - 1));

	acc_stab_cnt #(
		.CYCLES    (STAB_CYCLES)
	) u_stab (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.load_i    (stab_load),
		.abort_i   (stab_abort),
		.done_o    (stab_done)
	);

	acc_sar u_sar (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.start_i     (sar_start),
		.decide_i    (sar_decide),
		.bit_i       (sar_bit),
		.cmp_i       (cmp_val),
		.code_o      (sar_code),
		.code_next_o (sar_next)
	);

	assign stab_abort = (st_d.phase == ACC_OFF);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		st_d      = st_q;
		st_d.rdata = '0;
		stab_load = 1'b0;
		irq_evt   = '0;
		irq_clr   = '0;
		csr_rd    = '0;

		st_d.cmp_sync = {st_q.cmp_sync[1:0], comparator_i};
		st_d.cmp      = cmp_val;

		if (wr_csr)
		begin
			st_d.control_status_register.on   = bus.wdata[`ACC_CSR_ON_BIT];
			st_d.control_status_register.sel  = bus.wdata[`ACC_CSR_SEL_MSB:0];
			st_d.control_status_register.flag = 1'b0;
			st_d.cyc      = '0;
		end
		if (rd_result)
			st_d.control_status_register.flag = 1'b0;

		// clearing on or halt stops it, wait mode does nothing
		if (!st_d.control_status_register.on || halt_i)
		begin
			st_d.phase = ACC_OFF;
			st_d.cyc   = '0;
		end
		else
		begin
			case (st_q.phase)
				ACC_OFF:
				begin
					st_d.phase = ACC_STAB;
					stab_load  = 1'b1;
				end
				ACC_STAB:
				begin
					if (stab_done)
					begin
						st_d.phase                      = ACC_RUN;
						st_d.cyc                        = '0;
						irq_evt[`ACC_IRQ_READY_BIT]     = 1'b1;
					end
				end
				ACC_RUN:
				begin
					if (!wr_csr)
					begin
						if (st_q.cyc == `ACC_CYC_W'(`ACC_CONV_CYCLES - 1))
							st_d.cyc = '0;
						else
							st_d.cyc = st_q.cyc + 1'b1;
					end
				end
				default:
				begin
					st_d.phase = ACC_OFF;
				end
			endcase
		end

		// MSB lands in bit 7
		// A set here wins over a clear from a result read in the same cycle.
		if (conv_done)
		begin
			st_d.result   = sar_next;
			st_d.control_status_register.flag = 1'b1;
			if (st_q.control_status_register.flag && !rd_result)
				irq_evt[`ACC_IRQ_OVERRUN_BIT] = 1'b1;
		end

		// completion itself never reaches the interrupt line
		if (bus.wr && bus.addr == `ACC_OFS_IRQ_EN)
			st_d.irq_en = bus.wdata[`ACC_IRQ_W-1:0];
		if (bus.wr && bus.addr == `ACC_OFS_IRQ_CLR)
			irq_clr = bus.wdata[`ACC_IRQ_W-1:0];
		st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_evt;
		st_d.irq      = |(st_d.irq_stat & st_d.irq_en);

		st_d.power  = (st_d.phase != ACC_OFF);
		st_d.sample = (st_d.phase == ACC_RUN) &&
			(st_d.cyc < `ACC_CYC_W'(`ACC_SAMPLE_CYCLES));
		// only the analog switch moves, digital input stays live
		st_d.chan_en = st_d.power ? (`ACC_CHAN_N'(1) << st_d.control_status_register.sel) : '0;

		// bit 4 and reserved bits read zero
		csr_rd[`ACC_CSR_FLAG_BIT]       = st_q.control_status_register.flag;
		csr_rd[`ACC_CSR_ON_BIT]         = st_q.control_status_register.on;
		csr_rd[`ACC_CSR_SEL_MSB:0]      = st_q.control_status_register.sel;

		// a result read returns the value stored this cycle, other reads return the registered value
		if (bus.rd)
		begin
			case (bus.addr)
				`ACC_OFS_RESULT:   st_d.rdata = st_d.result;
				`ACC_OFS_CSR:      st_d.rdata = csr_rd;
				`ACC_OFS_IRQ_STAT: st_d.rdata = `ACC_DATA_W'(st_q.irq_stat);
				`ACC_OFS_IRQ_EN:   st_d.rdata = `ACC_DATA_W'(st_q.irq_en);
				default:           st_d.rdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	// everything clears on reset
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign rdata_o           = st_q.rdata;
	assign irq_o             = st_q.irq;
	assign converter_power_o = st_q.power;
	assign sample_o          = st_q.sample;
	assign analog_input_en_o = st_q.chan_en;
	assign dac_code_o        = sar_code;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			all_hi_q <= 1'b0;
			all_lo_q <= 1'b0;
		end
		else if (sar_start)
		begin
			all_hi_q <= 1'b1;
			all_lo_q <= 1'b1;
		end
		else if (sar_decide)
		begin
			all_hi_q <= all_hi_q && cmp_val;
			all_lo_q <= all_lo_q && !cmp_val;
		end
	end

	AST_FULL_SCALE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		conv_done && all_hi_q && cmp_val |=> st_q.result == `ACC_RESULT_FULL)
		else $error("full scale input did not give all ones");
	AST_ZERO_SCALE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		conv_done && all_lo_q && !cmp_val |=> st_q.result == `ACC_RESULT_ZERO)
		else $error("zero input did not give zero");
	AST_CONV_TIMING: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		conv_done |-> $past(sar_start, 32) && $past(sample_o, 33) && !sample_o)
		else $error("conversion length or sample window wrong");
	AST_STAB_FIRST: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		$rose(st_q.phase == ACC_RUN) |-> $past(stab_done))
		else $error("conversion started before settling");
	AST_DONE_UPDATE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		conv_done |=> st_q.control_status_register.flag && st_q.result == $past(sar_next))
		else $error("flag and result not updated together");
	AST_NO_DONE_IRQ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		conv_done && !st_q.control_status_register.flag && !irq_o && !bus.wr |=> !irq_o)
		else $error("completion raised an interrupt");
	AST_WRITE_RESTART: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		wr_csr && running && bus.wdata[`ACC_CSR_ON_BIT] && !halt_i
		|=> running && st_q.cyc == '0 && !st_q.control_status_register.flag)
		else $error("control write did not restart");
	AST_READ_CLEAR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		rd_result && !conv_done |=> !st_q.control_status_register.flag)
		else $error("result read left flag set");
	AST_OFF_STOP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		wr_csr && !bus.wdata[`ACC_CSR_ON_BIT] |=> !converter_power_o && !sample_o)
		else $error("converter still powered after switch off");
	AST_HALT_WAKE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		halt_i ##1 !halt_i && st_q.control_status_register.on && !wr_csr |=> st_q.phase == ACC_STAB)
		else $error("halt wakeup skipped settling");
	AST_CHAN_SEL: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		converter_power_o |-> analog_input_en_o == (`ACC_CHAN_N'(1) << st_q.control_status_register.sel))
		else $error("wrong analog input selected");
	AST_RSVD_ZERO: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		bus.rd && bus.addr == `ACC_OFS_CSR |=> !rdata_o[`ACC_CSR_FIXED_ZERO_BIT]
		&& !rdata_o[`ACC_CSR_RSVD_HI_BIT] && !rdata_o[`ACC_CSR_RSVD_LO_BIT])
		else $error("reserved control bit read as one");

endmodule // acc_top

`default_nettype wire

// *** inc/acc_regs.svh ***
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ACC_ADDR_W             8
`define ACC_DATA_W             8
`define ACC_OFS_RESULT         8'h70
`define ACC_OFS_CSR            8'h71
`define ACC_OFS_IRQ_STAT       8'h72
`define ACC_OFS_IRQ_EN         8'h73
`define ACC_OFS_IRQ_CLR        8'h74

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ACC_CSR_FLAG_BIT       7
`define ACC_CSR_RSVD_HI_BIT    6
`define ACC_CSR_ON_BIT         5
`define ACC_CSR_FIXED_ZERO_BIT 4
`define ACC_CSR_RSVD_LO_BIT    3
`define ACC_CSR_SEL_MSB        2
`define ACC_SEL_W              3
`define ACC_CHAN_N             8
`define ACC_RST_VALUE          8'h00
`define ACC_RESULT_FULL        8'hFF
`define ACC_RESULT_ZERO        8'h00
`define ACC_IRQ_W              2
`define ACC_IRQ_READY_BIT      0
`define ACC_IRQ_OVERRUN_BIT    1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACC_CLK_MHZ            250
`define ACC_STAB_TIME_NS       30000
`define ACC_STAB_CYCLES        ((`ACC_STAB_TIME_NS * `ACC_CLK_MHZ) / 1000)
`define ACC_STAB_CNT_W         16
`define ACC_CONV_CYCLES        64
`define ACC_SAMPLE_HALF_CYC    63
`define ACC_SAMPLE_CYCLES      ((`ACC_SAMPLE_HALF_CYC + 1) / 2)
`define ACC_BIT_SLOT           ((`ACC_CONV_CYCLES - `ACC_SAMPLE_CYCLES) / `ACC_DATA_W)
`define ACC_CYC_W              6
`define ACC_BIT_IDX_W          3

`endif

// *** inc/acc_pkg.sv ***
`default_nettype none
`include "acc_regs.svh"

package acc_pkg;

	typedef enum logic [1:0] {ACC_OFF, ACC_STAB, ACC_RUN} acc_phase_t;

	typedef struct packed {
		logic [`ACC_ADDR_W-1:0] addr;
		logic [`ACC_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} acc_bus_t;

	typedef struct packed {
		logic                  flag;
		logic                  on;
		logic [`ACC_SEL_W-1:0] sel;
	} acc_csr_t;

	typedef struct packed {
		logic [`ACC_STAB_CNT_W-1:0] cnt;
		logic                       busy;
		logic                       done;
	} acc_stab_st_t;

	typedef struct packed {
		logic [`ACC_DATA_W-1:0] code;
	} acc_sar_st_t;

	typedef struct packed {
		acc_phase_t             phase;
		logic [`ACC_CYC_W-1:0]  cyc;
		acc_csr_t               control_status_register;
		logic [`ACC_DATA_W-1:0] result;
		logic [`ACC_DATA_W-1:0] rdata;
		logic [2:0]             cmp_sync;
		logic                   cmp;
		logic [`ACC_IRQ_W-1:0]  irq_stat;
		logic [`ACC_IRQ_W-1:0]  irq_en;
		logic                   irq;
		logic                   power;
		logic                   sample;
		logic [`ACC_CHAN_N-1:0] chan_en;
	} acc_top_st_t;

endpackage

`default_nettype wire

// *** design/acc_stab_cnt.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_stab_cnt
	import acc_pkg::*;
#(
	parameter int unsigned CYCLES = `ACC_STAB_CYCLES
)
(
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	input  wire logic load_i,
	input  wire logic abort_i,
	output logic      done_o
);

	acc_stab_st_t st_q;
	acc_stab_st_t st_d;

	always_comb
	begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (abort_i)
			st_d.busy = 1'b0;
		else if (load_i)
		begin
			st_d.cnt  = `ACC_STAB_CNT_W'(CYCLES);
			st_d.busy = 1'b1;
		end
		else if (st_q.busy)
		begin
			st_d.cnt = st_q.cnt - 1'b1;
			if (st_q.cnt == `ACC_STAB_CNT_W'(1))
			begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign done_o = st_q.done;

endmodule // acc_stab_cnt

`default_nettype wire

// *** design/acc_sar.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_sar
	import acc_pkg::*;
(
	input  wire logic                      mclk_i,
	input  wire logic                      reset_n_i,
	input  wire logic                      start_i,
	input  wire logic                      decide_i,
	input  wire logic [`ACC_BIT_IDX_W-1:0] bit_i,
	input  wire logic                      cmp_i,
	output logic [`ACC_DATA_W-1:0]         code_o,
	output logic [`ACC_DATA_W-1:0]         code_next_o
);

	acc_sar_st_t            st_q;
	acc_sar_st_t            st_d;
	logic [`ACC_DATA_W-1:0] nxt;

	genvar g;
	generate
		for (g = 0; g < `ACC_DATA_W; g++)
		begin : g_bit
			assign nxt[g] = start_i ? (g == `ACC_DATA_W - 1) :
				(decide_i && bit_i == g) ? cmp_i :
				(decide_i && bit_i == g + 1) ? 1'b1 : st_q.code[g];
		end
	endgenerate

	always_comb
	begin
		st_d      = st_q;
		st_d.code = nxt;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign code_o      = st_q.code;
	assign code_next_o = nxt;

endmodule // acc_sar

`default_nettype wire

// *** tb/acc_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module acc_analog_model
	import acc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic [7:0]  chan_en_i,
	input  wire logic [7:0]  dac_code_i,
	input  wire logic [63:0] levels_i,
	output logic             comparator_o
);
	logic [7:0] level;
	logic       idle_q = 1'b0;

	always_comb
	begin
		level = 8'h00;
		for (int i = 0; i < 8; i++)
			if (chan_en_i[i])
				level = levels_i[i*8 +: 8];
	end

	// With no input selected the comparator wanders, so stale decisions show up.
	always @(posedge mclk_i)
		idle_q <= ~idle_q;

	assign comparator_o = (chan_en_i == 8'h00) ? idle_q : (level >= dac_code_i);
endmodule // acc_analog_model

`default_nettype wire

// *** tb/acc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module acc_top_test
	import acc_pkg::*;
	;
	localparam int unsigned STAB = 8;
	localparam int          LIMIT = 20000;

	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        halt = 1'b0;
	logic        cmp;
	logic [7:0]  rdata;
	logic        irq;
	logic        power;
	logic        sample;
	logic [7:0]  chan_en;
	logic [7:0]  dac;
	logic [63:0] levels = 64'h0000_0000_0000_0000;
	int          err_count = 0;
	int          n_tests = 0;
	int          cycles = 0;

	always #2 mclk = ~mclk;

	acc_top #(.STAB_CYCLES(STAB)) dut_u (
		.mclk_i(mclk),
		.reset_n_i(rst_n),
		.addr_i(addr),
		.wdata_i(wdata),
		.wr_i(wr),
		.rd_i(rd),
		.rdata_o(rdata),
		.halt_i(halt),
		.comparator_i(cmp),
		.irq_o(irq),
		.converter_power_o(power),
		.sample_o(sample),
		.analog_input_en_o(chan_en),
		.dac_code_o(dac)
	);

	acc_analog_model model_u (
		.mclk_i(mclk),
		.chan_en_i(chan_en),
		.dac_code_i(dac),
		.levels_i(levels),
		.comparator_o(cmp)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A hang counts as a mismatch and still gives a verdict.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			err_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge mclk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_flag();
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < 100 && d[7] !== 1'b1; i++)
			rd_reg(8'h71, d);
		check({7'h00, d[7]}, 8'h01);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] d;
		rd_reg(8'h70, d);
		check(d, 8'h00);
		rd_reg(8'h71, d);
		check(d, 8'h00);
		check({power, irq, 6'h00}, 8'h00);
		check(dac, 8'h00);
		wr_reg(8'h70, 8'h55);
		rd_reg(8'h70, d);
		check(d, 8'h00);
		rd_reg(8'h80, d);
		check(d, 8'h00);
	endtask

	task automatic t_csr();
		logic [7:0] d;
		wr_reg(8'h71, 8'hFF);
		rd_reg(8'h71, d);
		check(d, 8'h27);
		check({7'h00, power}, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			wr_reg(8'h71, 8'h20 | 8'(i));
			tick();
			check(chan_en, 8'h01 << i);
		end
		wr_reg(8'h71, 8'h00);
		repeat (2) tick();
		check({chan_en[6:0], power}, 8'h00);
	endtask

	task automatic t_convert(input logic [2:0] ch, input logic [7:0] lvl);
		logic [7:0] d;
		levels[{ch, 3'b000} +: 8] = lvl;
		wr_reg(8'h71, {5'b00100, ch});
		wait_flag();
		rd_reg(8'h70, d);
		check(d, lvl);
		rd_reg(8'h71, d);
		check(d, {5'b00100, ch});
	endtask

	task automatic t_period();
		int hi;
		int per;
		hi = 0;
		per = 0;
		for (int i = 0; i < 100 && sample !== 1'b0; i++)
			tick();
		for (int i = 0; i < 100 && sample !== 1'b1; i++)
			tick();
		while (sample === 1'b1 && per < 100)
		begin
			tick();
			hi++;
			per++;
		end
		while (sample !== 1'b1 && per < 100)
		begin
			tick();
			per++;
		end
		check(8'(hi), 8'h20);
		check(8'(per), 8'h40);
	endtask

	task automatic t_abort();
		logic [7:0] d;
		t_convert(3'h1, 8'h11);
		levels[39:32] = 8'hC3;
		wr_reg(8'h71, 8'h24);
		repeat (58) tick();
		rd_reg(8'h71, d);
		check(d, 8'h24);
		wait_flag();
		rd_reg(8'h70, d);
		check(d, 8'hC3);
	endtask

	task automatic t_irq();
		logic [7:0] d;
		wr_reg(8'h71, 8'h00);
		wr_reg(8'h74, 8'h03);
		wr_reg(8'h73, 8'h01);
		wr_reg(8'h71, 8'h20);
		repeat (STAB + 6) tick();
		check({7'h00, irq}, 8'h01);
		wr_reg(8'h73, 8'h00);
		repeat (2) tick();
		check({7'h00, irq}, 8'h00);
		rd_reg(8'h72, d);
		check(d, 8'h01);
		wr_reg(8'h73, 8'h03);
		wr_reg(8'h74, 8'h01);
		repeat (2) tick();
		check({7'h00, irq}, 8'h00);
		wait_flag();
		rd_reg(8'h70, d);
		check({7'h00, irq}, 8'h00);
		repeat (140) tick();
		check({7'h00, irq}, 8'h01);
		rd_reg(8'h72, d);
		check(d, 8'h02);
		wr_reg(8'h74, 8'h02);
		repeat (2) tick();
		check({7'h00, irq}, 8'h00);
	endtask

	task automatic t_halt();
		logic [7:0] d;
		levels[23:16] = 8'h3C;
		wr_reg(8'h71, 8'h22);
		halt <= 1'b1;
		repeat (3) tick();
		check({chan_en[6:0], power}, 8'h00);
		@(posedge mclk);
		halt <= 1'b0;
		repeat (STAB) tick();
		check({7'h00, sample}, 8'h00);
		wait_flag();
		rd_reg(8'h70, d);
		check(d, 8'h3C);
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_csr();
		t_convert(3'h3, 8'hFF);
		t_convert(3'h6, 8'h00);
		t_convert(3'h0, 8'h5A);
		t_convert(3'h7, 8'hA5);
		t_period();
		t_abort();
		t_irq();
		t_halt();
		end_of_test();
	end
endmodule // acc_top_test

`default_nettype wire
